// [dho_pkg.sv]
// shared types and constants of the holdover mode sequencer
// assumes a single 250 MHz system clock and a 1 ms enable tick
package dho_pkg;

   localparam int unsigned MCLK_HZ     = 250_000_000;
   localparam int unsigned TICK_MS     = 1;
   localparam int unsigned TICK_CYC    = MCLK_HZ / 1000 * TICK_MS;
   localparam int unsigned LOCK_S      = 1;
   localparam int unsigned LOCK_TICKS  = LOCK_S * 1000 / TICK_MS;
   localparam int unsigned TMO_S       = 100;
   localparam int unsigned TMO_TICKS   = TMO_S * 1000 / TICK_MS;

   localparam int unsigned FREQ_W      = 19;
   localparam int unsigned CNT_W       = 17;
   localparam int unsigned DIV_W       = 18;
   localparam int unsigned PER_W       = 16;

   // iir shift: tau = 2**k ms; fast ~66 s (7 min period), slow ~1050 s (110 min period)
   localparam int unsigned IIR_FRAC    = 20;
   localparam logic [4:0]  IIR_K_FAST  = 5'h10;
   localparam logic [4:0]  IIR_K_SLOW  = 5'h14;

   localparam logic [2:0]  CODE_FREE   = 3'h1;
   localparam logic [2:0]  CODE_HOLD   = 3'h2;
   localparam logic [2:0]  CODE_LOCK   = 3'h4;
   localparam logic [2:0]  CODE_PRE2   = 3'h5;
   localparam logic [2:0]  CODE_PRE    = 3'h6;
   localparam logic [2:0]  CODE_LOST   = 3'h7;

   localparam logic [1:0]  MINI_INT    = 2'h0;
   localparam logic [1:0]  MINI_AVG    = 2'h1;
   localparam logic [1:0]  MINI_MAN    = 2'h2;
   localparam logic [1:0]  MINI_ZERO   = 2'h3;

   localparam logic [FREQ_W-1:0] FREQ_RST = 19'h00000;

   typedef enum logic [2:0] {
      ST_FREE, ST_PRE, ST_LOCK, ST_LOST, ST_HOLD, ST_PRE2
   } dho_state_t;

   typedef struct packed {
      logic              man_holdover;
      logic              auto_averaging;
      logic              fast_averaging;
      logic              read_average;
      logic [1:0]        mini_mode;
      logic [FREQ_W-1:0] hold_freq;
      logic [PER_W-1:0]  ref_period;
   } dho_cfg_t;

   typedef struct packed {
      logic ref_selected;
      logic ref_valid;
      logic new_source;
      logic standby_good;
      logic bucket_trig;
      logic revert_restore;
      logic phase_locked;
   } dho_sel_t;

   function automatic logic [2:0] dho_code(input dho_state_t s);
      unique case (s)
         ST_FREE: dho_code = CODE_FREE;
         ST_PRE:  dho_code = CODE_PRE;
         ST_LOCK: dho_code = CODE_LOCK;
         ST_LOST: dho_code = CODE_LOST;
         ST_HOLD: dho_code = CODE_HOLD;
         ST_PRE2: dho_code = CODE_PRE2;
         default: dho_code = CODE_FREE;
      endcase
   endfunction

endpackage

// [dho_sync3.sv]
// three-stage pin synchroniser, output changes once stages two and three agree
// assumes d is asynchronous to mclk
`timescale 1ns/1ps
`default_nettype none
module dho_sync3 (
   // clock and reset
   input  wire logic mclk,
   input  wire logic rst_n,
   // pin and level
   input  wire logic d,
   output var  logic q
);
   logic s1_r;
   logic s2_r;
   logic s3_r;

   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         s1_r <= 1'b0;
         s2_r <= 1'b0;
         s3_r <= 1'b0;
      end else begin
         s1_r <= d;
         s2_r <= s1_r;
         s3_r <= s2_r;
      end
   end

   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         q <= 1'b0;
      end else if (s2_r == s3_r) begin
         q <= s3_r;
      end
   end
endmodule
`default_nettype wire

// [dho_iir.sv]
// first-order iir averaging of the loop frequency word
// assumes en is a slow sample tick; shift picks the time constant
`timescale 1ns/1ps
`default_nettype none
module dho_iir
   import dho_pkg::*;
(
   // clock and reset
   input  wire logic                     mclk,
   input  wire logic                     rst_n,
   // sample in
   input  wire logic                     en,
   input  wire logic                     fast,
   input  wire logic signed [FREQ_W-1:0] x,
   // average out
   output var  logic signed [FREQ_W-1:0] y
);
   localparam int unsigned AW = FREQ_W + IIR_FRAC;

   logic signed [AW-1:0] acc_r;
   logic signed [AW:0]   diff;
   logic signed [AW:0]   step;

   always_comb begin
      diff = {x[FREQ_W-1], x, {IIR_FRAC{1'b0}}} - {acc_r[AW-1], acc_r};
      step = diff >>> (fast ? IIR_K_FAST : IIR_K_SLOW);
   end

   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         acc_r <= '0;
      end else if (en) begin
         acc_r <= acc_r + step[AW-1:0];
      end
   end

   assign y = acc_r[AW-1:IIR_FRAC];
endmodule
`default_nettype wire

// [dho_mode_ctl.sv]
// operating-mode sequencer of the main timing loop with holdover frequency choice
// assumes selection/qualification logic on mclk and a reference clock pin to watch
// How it works
// - phase loss while locked enters lost-phase
// - lost-phase keeps tracking, relock returns locked
// - bucket or 100 s timeout disqualifies, timeout alarms
// - after disqualify: standby gives pre-locked2, else holdover
// - invalid input without replacement while locked enters holdover
// - manual bit picks manual or automatic holdover
// - averaging bit picks averaged or instantaneous
// - averaged mode filters frequency, fast and slow
// - fast bit selects fast filter response
// - instantaneous holds integral value, no proportional
// - manual uses written 19-bit signed offset
// - current frequency status from integral path
// - read-average returns filtered value, any state
// - freeze frequency within two missing ref cycles
// - four mini-holdover frequency methods by field
// - mini-holdover ends on reselect, holdover, recovery
// - holdover to pre-locked2 on selection or revert
// - pre-locked2 100 s timeout returns holdover, reselect
// - locked only after one second continuous lock
// - state reported as 3-bit code
`timescale 1ns/1ps
`default_nettype none
module dho_mode_ctl
   import dho_pkg::*;
#(
   parameter logic [DIV_W-1:0] TICK_CYCLES = DIV_W'(TICK_CYC),
   parameter logic [CNT_W-1:0] LOCK_T      = CNT_W'(LOCK_TICKS),
   parameter logic [CNT_W-1:0] TMO_T       = CNT_W'(TMO_TICKS)
) (
   // clock and reset
   input  wire logic                     mclk,
   input  wire logic                     rst_n,
   // configuration and selection status
   input  wire dho_cfg_t                 cfg,
   input  wire dho_sel_t                 sel,
   input  wire logic                     alarm_clr,
   // reference clock pin
   input  wire logic                     ref_clk_pin,
   // loop integral path
   input  wire logic signed [FREQ_W-1:0] loop_integral,
   // loop control
   output var  logic signed [FREQ_W-1:0] freq_ctl,
   output var  logic                     loop_open,
   output var  logic                     prop_en,
   output var  logic                     mini_hold,
   // requests to selection
   output var  logic                     disqualify,
   output var  logic                     reselect,
   // status
   output var  logic [2:0]               main_loop_state_code,
   output var  logic signed [FREQ_W-1:0] loop_freq_status,
   output var  logic signed [FREQ_W-1:0] hold_freq_rd,
   output var  logic                     phase_alarm
);
   dho_state_t               state_r;
   dho_state_t               state_nxt;
   logic [DIV_W-1:0]         div_r;
   logic                     tick_r;
   logic [CNT_W-1:0]         lock_cnt_r;
   logic [CNT_W-1:0]         tim_r;
   logic                     lock_done;
   logic                     tmo;
   logic                     disq_nxt;
   logic                     resel_nxt;
   logic                     alarm_set;
   logic                     ref_lvl;
   logic                     ref_lvl_d_r;
   logic                     ref_edge;
   logic [PER_W:0]           gap_r;
   logic                     miss;
   logic signed [FREQ_W-1:0] avg;
   logic signed [FREQ_W-1:0] hold_inst_r;
   logic signed [FREQ_W-1:0] mini_cap_r;
   logic signed [FREQ_W-1:0] hold_val;
   logic signed [FREQ_W-1:0] mini_val;
   logic                     mini_end;

   // 1 ms enable
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         div_r  <= '0;
         tick_r <= 1'b0;
      end else begin
         tick_r <= (div_r == TICK_CYCLES - 1'b1);
         div_r  <= (div_r == TICK_CYCLES - 1'b1) ? '0 : div_r + 1'b1;
      end
   end

   // continuous lock qualification
   assign lock_done = tick_r && sel.phase_locked && sel.ref_selected
                      && (lock_cnt_r == LOCK_T - 1'b1);

   always_ff @(posedge mclk) begin
      if (!rst_n || state_nxt != state_r || !sel.phase_locked || !sel.ref_selected) begin
         lock_cnt_r <= '0;
      end else if (tick_r && lock_cnt_r != LOCK_T - 1'b1) begin
         lock_cnt_r <= lock_cnt_r + 1'b1;
      end
   end

   // time spent in the current state
   assign tmo = tick_r && (tim_r == TMO_T - 1'b1);

   always_ff @(posedge mclk) begin
      if (!rst_n || state_nxt != state_r) begin
         tim_r <= '0;
      end else if (tick_r && tim_r != TMO_T - 1'b1) begin
         tim_r <= tim_r + 1'b1;
      end
   end

   always_comb begin
      state_nxt = state_r;
      disq_nxt  = 1'b0;
      resel_nxt = 1'b0;
      alarm_set = 1'b0;
      unique case (state_r)
         ST_FREE: begin
            if (sel.ref_selected) begin
               state_nxt = ST_PRE;
            end
         end
         ST_PRE: begin
            if (lock_done) begin
               state_nxt = ST_LOCK;
            end else if (tmo) begin
               state_nxt = ST_FREE;
               resel_nxt = 1'b1;
            end
         end
         ST_LOCK: begin
            if (!sel.phase_locked) begin
               state_nxt = ST_LOST;
            end else if (!sel.ref_valid) begin
               state_nxt = sel.standby_good ? ST_PRE2 : ST_HOLD;
            end
         end
         ST_LOST: begin
            if (sel.bucket_trig || tmo) begin
               disq_nxt  = 1'b1;
               alarm_set = tmo && !sel.bucket_trig;
               state_nxt = sel.standby_good ? ST_PRE2 : ST_HOLD;
            end else if (lock_done) begin
               state_nxt = ST_LOCK;
            end
         end
         ST_HOLD: begin
            if ((sel.ref_selected && sel.ref_valid) || sel.revert_restore) begin
               state_nxt = ST_PRE2;
            end
         end
         ST_PRE2: begin
            if (lock_done) begin
               state_nxt = ST_LOCK;
            end else if (tmo) begin
               state_nxt = ST_HOLD;
               resel_nxt = 1'b1;
            end
         end
         default: state_nxt = ST_FREE;
      endcase
   end

   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         state_r <= ST_FREE;
      end else begin
         state_r <= state_nxt;
      end
   end

   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         disqualify <= 1'b0;
         reselect   <= 1'b0;
      end else begin
         disqualify <= disq_nxt;
         reselect   <= resel_nxt;
      end
   end

   // sticky alarm, set beats clear
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         phase_alarm <= 1'b0;
      end else if (alarm_set) begin
         phase_alarm <= 1'b1;
      end else if (alarm_clr) begin
         phase_alarm <= 1'b0;
      end
   end

   // missing reference clock watch
   dho_sync3 u_ref_sync (
      .mclk  (mclk),
      .rst_n (rst_n),
      .d     (ref_clk_pin),
      .q     (ref_lvl)
   );

   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         ref_lvl_d_r <= 1'b0;
      end else begin
         ref_lvl_d_r <= ref_lvl;
      end
   end

   assign ref_edge = ref_lvl && !ref_lvl_d_r;

   always_ff @(posedge mclk) begin
      if (!rst_n || ref_edge) begin
         gap_r <= '0;
      end else if (!(&gap_r)) begin
         gap_r <= gap_r + 1'b1;
      end
   end

   // one and a half periods without an edge
   assign miss = gap_r > ({1'b0, cfg.ref_period} + {2'b00, cfg.ref_period[PER_W-1:1]});

   assign mini_end = sel.new_source || state_r == ST_HOLD || ref_edge;

   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         mini_hold  <= 1'b0;
         mini_cap_r <= FREQ_RST;
      end else if (mini_hold) begin
         mini_hold <= !mini_end;
      end else if (miss && !mini_end && state_r != ST_FREE) begin
         mini_hold  <= 1'b1;
         mini_cap_r <= loop_integral;
      end
   end

   // instantaneous value captured at holdover entry
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         hold_inst_r <= FREQ_RST;
      end else if (state_nxt == ST_HOLD && state_r != ST_HOLD) begin
         hold_inst_r <= mini_hold ? mini_cap_r : loop_integral;
      end
   end

   dho_iir u_avg (
      .mclk  (mclk),
      .rst_n (rst_n),
      .en    (tick_r && !loop_open),
      .fast  (cfg.fast_averaging),
      .x     (loop_integral),
      .y     (avg)
   );

   always_comb begin
      if (cfg.man_holdover) begin
         hold_val = cfg.hold_freq;
      end else if (cfg.auto_averaging) begin
         hold_val = avg;
      end else begin
         hold_val = hold_inst_r;
      end
      unique case (cfg.mini_mode)
         MINI_INT:  mini_val = mini_cap_r;
         MINI_AVG:  mini_val = avg;
         MINI_MAN:  mini_val = cfg.hold_freq;
         MINI_ZERO: mini_val = FREQ_RST;
      endcase
   end

   // loop steering
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         freq_ctl  <= FREQ_RST;
         loop_open <= 1'b1;
         prop_en   <= 1'b0;
      end else if (state_r == ST_HOLD) begin
         freq_ctl  <= hold_val;
         loop_open <= 1'b1;
         prop_en   <= 1'b0;
      end else if (mini_hold) begin
         freq_ctl  <= mini_val;
         loop_open <= 1'b1;
         prop_en   <= 1'b0;
      end else begin
         freq_ctl  <= FREQ_RST;
         loop_open <= state_r == ST_FREE;
         prop_en   <= state_r != ST_FREE;
      end
   end

   // status
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         main_loop_state_code <= CODE_FREE;
         loop_freq_status     <= FREQ_RST;
         hold_freq_rd         <= FREQ_RST;
      end else begin
         main_loop_state_code <= dho_code(state_r);
         loop_freq_status     <= loop_integral;
         hold_freq_rd         <= cfg.read_average ? avg : cfg.hold_freq;
      end
   end

   default clocking cb @(posedge mclk); endclocking
   default disable iff (!rst_n);

   sequence s_hold2;
      state_r == ST_HOLD ##1 state_r == ST_HOLD && !mini_hold;
   endsequence

   lost_entry_a: assert property (state_r == ST_LOCK && !sel.phase_locked |=> state_r == ST_LOST)
      else $error("no lost-phase on phase loss");
   relock_a: assert property (state_r == ST_LOST && !sel.bucket_trig && !tmo && lock_done |=> state_r == ST_LOCK)
      else $error("no relock from lost-phase");
   disq_pulse_a: assert property (state_r == ST_LOST && sel.bucket_trig |=> disqualify ##1 !disqualify)
      else $error("disqualify not pulsed");
   tmo_alarm_a: assert property (state_r == ST_LOST && tmo && !sel.bucket_trig |=> phase_alarm && disqualify)
      else $error("timeout alarm missing");
   disq_dest_a: assert property (disq_nxt |=> state_r == ($past(sel.standby_good) ? ST_PRE2 : ST_HOLD))
      else $error("wrong state after disqualify");
   hold_prop_a: assert property (s_hold2 |=> !prop_en && loop_open)
      else $error("proportional path active in holdover");
   man_freq_a: assert property (state_r == ST_HOLD && cfg.man_holdover |=> freq_ctl == $past(cfg.hold_freq))
      else $error("manual offset not applied");
   read_avg_a: assert property (cfg.read_average |=> hold_freq_rd == $past(avg))
      else $error("filtered readback wrong");
   mini_end_a: assert property (mini_hold && state_r == ST_HOLD |=> !mini_hold)
      else $error("mini-holdover outlived holdover entry");
   pre2_tmo_a: assert property (state_r == ST_PRE2 && tmo && !lock_done |=> state_r == ST_HOLD && reselect)
      else $error("pre-locked2 timeout not handled");
   lock_qual_a: assert property (state_r != ST_LOCK ##1 state_r == ST_LOCK |-> $past(lock_done))
      else $error("locked without qualification");
   code_out_a: assert property (##1 main_loop_state_code == dho_code($past(state_r)))
      else $error("state code mismatch");
endmodule
`default_nettype wire

// [dho_sel_model.sv]
// partner model: reference selection and qualification plus the reference clock pin
// assumes bench commands change just after the falling edge of mclk
`timescale 1ns/1ps
`default_nettype none
module dho_sel_model
   import dho_pkg::*;
(
   // clock
   input  wire logic        mclk,
   // bench commands
   input  wire logic        src_ok,
   input  wire logic        pin_on,
   input  wire logic        lock_ok,
   input  wire logic        standby,
   input  wire logic        bucket,
   input  wire logic        revert,
   input  wire logic [15:0] half_per,
   // requests from the sequencer
   input  wire logic        disqualify,
   input  wire logic        reselect,
   // to the sequencer
   output var  dho_sel_t    sel,
   output var  logic        ref_pin
);
   logic        drop_r = 1'b0;
   logic        selp_r = 1'b0;
   logic [15:0] ph_r   = 16'h0000;
   wire  logic  sel_now = src_ok & ~drop_r;

   initial ref_pin = 1'b0;

   // a disqualified source stays dropped until the bench withdraws it
   always @(negedge mclk) begin
      if (!src_ok)
         drop_r <= 1'b0;
      else if (disqualify || reselect)
         drop_r <= 1'b1;
      selp_r <= sel_now;
   end

   // a failed reference stands still low
   always @(negedge mclk) begin
      if (!pin_on) begin
         ref_pin <= 1'b0;
         ph_r    <= 16'h0000;
      end else if (ph_r == 16'(half_per - 16'h0001)) begin
         ref_pin <= ~ref_pin;
         ph_r    <= 16'h0000;
      end else
         ph_r <= 16'(ph_r + 16'h0001);
   end

   always_comb begin
      sel.ref_selected   = sel_now;
      sel.ref_valid      = sel_now;
      sel.new_source     = sel_now & ~selp_r;
      sel.standby_good   = standby;
      sel.bucket_trig    = bucket;
      sel.revert_restore = revert;
      sel.phase_locked   = lock_ok;
   end
endmodule
`default_nettype wire

// [dho_mode_ctl_tb_top.sv]
// self-checking bench of the holdover mode sequencer
// assumes shortened tick and timeout parameters, partner model on the selection side
`timescale 1ns/1ps
`default_nettype none
module dho_mode_ctl_tb_top
   import dho_pkg::*;
();
   logic                     mclk;
   logic                     rst_n;
   dho_cfg_t                 cfg;
   dho_sel_t                 sel;
   logic                     alarm_clr;
   logic signed [FREQ_W-1:0] integ;
   logic                     src_ok, pin_on, lock_ok, standby, bucket, revert;
   wire  logic               ref_pin;
   wire  logic signed [18:0] freq_ctl, loop_freq_status, hold_freq_rd;
   wire  logic               loop_open, prop_en, mini_hold, disqualify, reselect, phase_alarm;
   wire  logic [2:0]         main_loop_state_code;
   logic [2:0]               exp_q[$];
   logic [2:0]               last_code;
   int                       err_total = 0;
   int                       n_compared = 0;
   int                       n_dq = 0;
   int                       n_rs = 0;
   int                       n_wait;

   dho_sel_model ptn (.mclk(mclk), .src_ok(src_ok), .pin_on(pin_on), .lock_ok(lock_ok),
      .standby(standby), .bucket(bucket), .revert(revert), .half_per(16'h0004),
      .disqualify(disqualify), .reselect(reselect), .sel(sel), .ref_pin(ref_pin));

   dho_mode_ctl #(.TICK_CYCLES(18'h0000a), .LOCK_T(17'h00004), .TMO_T(17'h00014)) dut (
      .mclk(mclk), .rst_n(rst_n), .cfg(cfg), .sel(sel), .alarm_clr(alarm_clr),
      .ref_clk_pin(ref_pin), .loop_integral(integ), .freq_ctl(freq_ctl), .loop_open(loop_open),
      .prop_en(prop_en), .mini_hold(mini_hold), .disqualify(disqualify), .reselect(reselect),
      .main_loop_state_code(main_loop_state_code), .loop_freq_status(loop_freq_status),
      .hold_freq_rd(hold_freq_rd), .phase_alarm(phase_alarm));

   initial begin
      mclk = 1'b0;
      forever #2 mclk = ~mclk;
   end

   task automatic check(input logic [18:0] seen, input logic [18:0] exp);
      n_compared++;
      if (seen !== exp) begin
         err_total++;
         $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic end_sim;
      $display("comparisons %0d, mismatches %0d", n_compared, err_total);
      if (err_total == 0 && n_compared > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask

   // note the next state code, then wait for it under a bound
   task automatic expect_code(input logic [2:0] c, input int max);
      exp_q.push_back(c);
      n_wait = 0;
      while (main_loop_state_code !== c && n_wait < max) begin
         @(negedge mclk);
         n_wait++;
      end
      check(19'(main_loop_state_code), 19'(c));
   endtask

   task automatic wait_mini(input logic v, input int max);
      int n;
      n = 0;
      while (mini_hold !== v && n < max) begin
         @(negedge mclk);
         n++;
      end
      check(19'(mini_hold), 19'(v));
   endtask

   // state code scoreboard: every change takes the oldest note
   always @(negedge mclk) begin
      if (rst_n && main_loop_state_code !== last_code) begin
         if (exp_q.size() == 0)
            check(19'(main_loop_state_code), 19'(last_code));
         else
            check(19'(main_loop_state_code), 19'(exp_q.pop_front()));
      end
      last_code <= main_loop_state_code;
      if (disqualify === 1'b1)
         n_dq++;
      if (reselect === 1'b1)
         n_rs++;
   end

   initial begin
      #40us;
      err_total++;
      end_sim();
   end

   initial begin
      logic signed [18:0] v, hf;
      void'($urandom(32'h5643));
      rst_n = 1'b0;
      cfg = '0;
      cfg.ref_period = 16'h0008;
      alarm_clr = 1'b0;
      integ = 19'h00000;
      {src_ok, pin_on, lock_ok, standby, bucket, revert} = 6'h00;
      repeat (8) @(negedge mclk);
      rst_n = 1'b1;
      @(negedge mclk);
      check(19'(main_loop_state_code), 19'(CODE_FREE));
      check(19'({loop_open, prop_en, mini_hold, phase_alarm}), 19'h00008);
      check(freq_ctl, 19'h00000);
      v = 19'($urandom % 64 + 1);
      hf = 19'($urandom);
      integ = v;
      cfg.hold_freq = hf;
      {src_ok, pin_on, lock_ok} = 3'h7;
      expect_code(CODE_PRE, 10);
      expect_code(CODE_LOCK, 80);
      check(19'(n_wait >= 30), 19'h00001);
      // kept non-negative so the slow average stays at zero
      integ = {1'b0, 18'($urandom)};
      @(negedge mclk);
      check(loop_freq_status, integ);
      hf = loop_freq_status;
      cfg.hold_freq = hf;
      integ = v;
      repeat (2) @(negedge mclk);
      check(hold_freq_rd, hf);
      cfg.read_average = 1'b1;
      repeat (2) @(negedge mclk);
      check(hold_freq_rd, 19'h00000);
      cfg.read_average = 1'b0;
      for (int m = 0; m < 4; m++) begin
         cfg.mini_mode = 2'(m);
         pin_on = 1'b0;
         wait_mini(1'b1, 30);
         repeat (2) @(negedge mclk);
         check(freq_ctl, (m == 0) ? v : (m == 2) ? hf : 19'h00000);
         check(19'({loop_open, prop_en}), 19'h00002);
         pin_on = 1'b1;
         wait_mini(1'b0, 24);
         repeat (4) @(negedge mclk);
      end
      lock_ok = 1'b0;
      expect_code(CODE_LOST, 5);
      lock_ok = 1'b1;
      expect_code(CODE_LOCK, 80);
      lock_ok = 1'b0;
      expect_code(CODE_LOST, 5);
      cfg.man_holdover = 1'b1;
      bucket = 1'b1;
      expect_code(CODE_HOLD, 5);
      bucket = 1'b0;
      repeat (2) @(negedge mclk);
      check(19'(n_dq), 19'h00001);
      check(19'(phase_alarm), 19'h00000);
      check(freq_ctl, hf);
      check(19'({loop_open, prop_en}), 19'h00002);
      revert = 1'b1;
      @(negedge mclk);
      revert = 1'b0;
      expect_code(CODE_PRE2, 5);
      expect_code(CODE_HOLD, 260);
      check(19'(n_wait >= 190), 19'h00001);
      repeat (2) @(negedge mclk);
      check(19'(n_rs), 19'h00001);
      src_ok = 1'b0;
      repeat (2) @(negedge mclk);
      src_ok = 1'b1;
      expect_code(CODE_PRE2, 5);
      lock_ok = 1'b1;
      expect_code(CODE_LOCK, 80);
      lock_ok = 1'b0;
      standby = 1'b1;
      expect_code(CODE_LOST, 5);
      expect_code(CODE_PRE2, 260);
      repeat (2) @(negedge mclk);
      check(19'({phase_alarm, 4'(n_dq)}), 19'h00012);
      alarm_clr = 1'b1;
      @(negedge mclk);
      alarm_clr = 1'b0;
      repeat (2) @(negedge mclk);
      check(19'(phase_alarm), 19'h00000);
      {src_ok, standby} = 2'h0;
      repeat (2) @(negedge mclk);
      {src_ok, lock_ok} = 2'h3;
      expect_code(CODE_LOCK, 90);
      pin_on = 1'b0;
      wait_mini(1'b1, 30);
      cfg.man_holdover = 1'b0;
      src_ok = 1'b0;
      expect_code(CODE_HOLD, 5);
      wait_mini(1'b0, 2);
      pin_on = 1'b1;
      repeat (2) @(negedge mclk);
      check(freq_ctl, v);
      cfg.auto_averaging = 1'b1;
      repeat (2) @(negedge mclk);
      check(freq_ctl, 19'h00000);
      // fast filter must move within a few ticks, slow one stays at zero
      {src_ok, lock_ok} = 2'h2;
      expect_code(CODE_PRE2, 5);
      integ = 19'h20000;
      cfg.fast_averaging = 1'b1;
      cfg.read_average = 1'b1;
      repeat (40) @(negedge mclk);
      check(19'(hold_freq_rd > 0), 19'h00001);
      end_sim();
   end
endmodule
`default_nettype wire
